// ===== logic/multi_module_acq_sync.sv
// Mode, trigger and sample clock steering for multi-module synchronisation.
// Notes on behaviour
// [RL1] Mode is master, slave or none.
// [RL2] Master drives trigger and clock onto link.
// [RL3] Slave takes trigger and clock from link.
// [RL4] Slave ignores external and threshold triggers.
// [RL5] Default none mode uses the local clock.
// [RL6] Local clock paces analog input and output.
// [RL7] Mode holds until changed or application exits.
// [RL8] At most four parallel, two daisy-chained.
// [RL9] Slaves are started before the master.
// [RL10] Master accepts any supported trigger source.
// [RL11] All modules start within one conversion.
// [RL12] Each module keeps its own sample rate.
// [RL13] Master stop leaves slaves running.
// [RL14] Started slave waits armed for link trigger.
`timescale 1ns/100ps
`default_nettype none
`include "acq_sync_defines.svh"
module multi_module_acq_sync #(
    parameter int RATE_W = 16
) (
    input  wire logic              clk_sys,       // System clock, 50 MHz, USB derived.
    input  wire logic              resetn,        // Asynchronous reset, active low.
    input  wire logic [1:0]        mode_code,     // Requested synchronisation mode.
    input  wire logic              mode_wr,       // Pulse: take mode_code.
    input  wire logic              app_exit,      // Pulse: application ended.
    input  wire logic [1:0]        trig_src,      // Trigger source when not slave.
    input  wire logic              sw_trig,       // Pulse: software trigger.
    input  wire logic              ext_trig,      // External trigger pin, asynchronous.
    input  wire logic              thresh_hit,    // Analog threshold comparator level.
    input  wire logic              ai_start,      // Pulse: start analog input.
    input  wire logic              ai_stop,       // Pulse: stop analog input.
    input  wire logic [RATE_W-1:0] rate_div,      // Base ticks per sample, 0 as 1.
    input  wire logic              link_clk_in,   // Link clock pin, asynchronous.
    input  wire logic              link_trig_in,  // Link trigger pin, asynchronous.
    output logic                   link_clk_out,  // Link clock drive.
    output logic                   link_trig_out, // Link trigger drive.
    output logic                   link_oe,       // High while driving the link.
    output logic [1:0]             mode_now,      // Mode in force.
    output logic                   armed,         // Waiting for trigger.
    output logic                   acquiring,     // Acquisition running.
    output logic                   sample_tick,   // Pulse: one analog input conversion.
    output logic                   ao_tick        // Pulse: analog output update.
);
    acq_sync_pkg::top_state_s s_reg;
    acq_sync_pkg::top_state_s s_next;
    logic                     ext_rise;
    logic                     ltrig_rise;
    logic                     lclk_rise;
    logic                     thresh_rise;
    logic                     src_hit;
    logic                     trig_hit;
    logic                     local_rise;
    logic                     is_slave;

    pacer_if #(.RATE_W(RATE_W)) pif ();

    generate
        if (RATE_W < 1 || RATE_W > 16) begin : g_bad_width
            $error("multi_module_acq_sync: RATE_W must lie between 1 and 16");
        end
        if (`ACQ_BASE_HALF_CYC < 1 || `ACQ_BASE_HALF_CYC > 255) begin : g_bad_half
            $error("multi_module_acq_sync: base clock half period out of range");
        end
    endgenerate

    // Pin levels count only once the second and third stages agree, which
    // rejects a single metastable or glitching sample.
    always_comb begin
        is_slave    = (s_reg.mode == acq_sync_pkg::MODE_SLAVE);
        ext_rise    = (s_reg.ext_sync[1] == s_reg.ext_sync[2]) && s_reg.ext_sync[2]
                      && !s_reg.ext_lvl;
        ltrig_rise  = (s_reg.ltrig_sync[1] == s_reg.ltrig_sync[2]) && s_reg.ltrig_sync[2]
                      && !s_reg.ltrig_lvl;
        lclk_rise   = (s_reg.lclk_sync[1] == s_reg.lclk_sync[2]) && s_reg.lclk_sync[2]
                      && !s_reg.lclk_lvl;
        thresh_rise = thresh_hit && !s_reg.thresh_prev;
        local_rise  = (s_reg.div_cnt == 8'(`ACQ_BASE_HALF_CYC - 1)) && !s_reg.lclk;
        case (trig_src)
            `ACQ_SRC_CODE_SW:     src_hit = sw_trig;      // RL10
            `ACQ_SRC_CODE_EXT:    src_hit = ext_rise;     // RL10
            `ACQ_SRC_CODE_THRESH: src_hit = thresh_rise;  // RL10
            default:              src_hit = 1'b0;
        endcase
        trig_hit = is_slave ? ltrig_rise : src_hit; // RL3 RL4
    end

    always_comb begin
        s_next             = s_reg;
        s_next.ext_sync    = {s_reg.ext_sync[1:0], ext_trig};
        s_next.ltrig_sync  = {s_reg.ltrig_sync[1:0], link_trig_in};
        s_next.lclk_sync   = {s_reg.lclk_sync[1:0], link_clk_in};
        if (s_reg.ext_sync[1] == s_reg.ext_sync[2]) begin
            s_next.ext_lvl = s_reg.ext_sync[2];
        end
        if (s_reg.ltrig_sync[1] == s_reg.ltrig_sync[2]) begin
            s_next.ltrig_lvl = s_reg.ltrig_sync[2];
        end
        if (s_reg.lclk_sync[1] == s_reg.lclk_sync[2]) begin
            s_next.lclk_lvl = s_reg.lclk_sync[2];
        end
        s_next.thresh_prev = thresh_hit;

        // The mode is only ever moved by an explicit write or an exit.
        if (app_exit) begin
            s_next.mode = acq_sync_pkg::MODE_NONE; // RL7
        end else if (mode_wr) begin
            case (mode_code)
                `ACQ_MODE_CODE_NONE:   s_next.mode = acq_sync_pkg::MODE_NONE;   // RL1
                `ACQ_MODE_CODE_MASTER: s_next.mode = acq_sync_pkg::MODE_MASTER; // RL1
                `ACQ_MODE_CODE_SLAVE:  s_next.mode = acq_sync_pkg::MODE_SLAVE;  // RL1
                default:               s_next.mode = s_reg.mode;
            endcase
        end

        // Local base clock from the USB-derived system clock.
        if (s_reg.div_cnt == 8'(`ACQ_BASE_HALF_CYC - 1)) begin
            s_next.div_cnt = '0;
            s_next.lclk    = !s_reg.lclk;
        end else begin
            s_next.div_cnt = 8'(s_reg.div_cnt + 1'b1);
        end
        s_next.base_tick = is_slave ? lclk_rise : local_rise; // RL3 RL5 RL6
        s_next.ao_tick   = s_next.base_tick;                  // RL6

        case (s_reg.state)
            acq_sync_pkg::ST_IDLE: begin
                if (ai_start) begin
                    s_next.state = acq_sync_pkg::ST_ARMED;
                end
            end
            acq_sync_pkg::ST_ARMED: begin
                if (ai_stop) begin
                    s_next.state = acq_sync_pkg::ST_IDLE;
                end else if (trig_hit) begin
                    s_next.state = acq_sync_pkg::ST_RUN; // RL14 RL11
                end
            end
            acq_sync_pkg::ST_RUN: begin
                // A slave ignores the link trigger falling; only its own stop ends it.
                if (ai_stop) begin
                    s_next.state = acq_sync_pkg::ST_IDLE; // RL13
                end
            end
            default: s_next.state = acq_sync_pkg::ST_IDLE;
        endcase

        s_next.link_oe       = (s_next.mode == acq_sync_pkg::MODE_MASTER); // RL2
        s_next.link_clk_out  = s_next.lclk;                                // RL2
        s_next.link_trig_out = s_next.link_oe
                               && (s_next.state == acq_sync_pkg::ST_RUN);  // RL2
        // Status levels get flops of their own so that no state decode reaches a pin;
        // they follow the state register in the same cycle.
        s_next.armed         = (s_next.state == acq_sync_pkg::ST_ARMED);  // RL14
        s_next.acquiring     = (s_next.state == acq_sync_pkg::ST_RUN);    // RL13
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0; // RL5
        end else begin
            s_reg <= s_next;
        end
    end

    assign pif.base_tick = s_reg.base_tick;
    assign pif.run       = (s_reg.state == acq_sync_pkg::ST_RUN); // RL14
    assign pif.rate_div  = rate_div;                               // RL12

    sample_pacer #(.RATE_W(RATE_W)) u_pacer (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pif     (pif.pacer)
    );

    assign link_clk_out  = s_reg.link_clk_out;
    assign link_trig_out = s_reg.link_trig_out;
    assign link_oe       = s_reg.link_oe;
    assign mode_now      = s_reg.mode;
    assign armed         = s_reg.armed;
    assign acquiring     = s_reg.acquiring;
    assign sample_tick   = pif.sample_tick;
    assign ao_tick       = s_reg.ao_tick;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_mode_hold: assert property (!mode_wr && !app_exit |=> $stable(mode_now)) // RL7
        else $error("mode changed without a write");
    chk_exit_to_none: assert property (app_exit |=> mode_now == `ACQ_MODE_CODE_NONE) // RL7
        else $error("exit did not return mode to none");
    chk_master_drives: assert property (link_oe == (mode_now == `ACQ_MODE_CODE_MASTER)) // RL2
        else $error("link drive does not follow master mode");
    chk_master_trig_out: assert property (link_trig_out |-> link_oe && acquiring) // RL2
        else $error("link trigger driven outside master run");
    chk_slave_ignores_local: assert property ( // RL4
        armed && is_slave && !ltrig_rise && !ai_stop |=> armed)
        else $error("slave left armed without link trigger");
    chk_slave_link_start: assert property ( // RL3
        armed && is_slave && ltrig_rise && !ai_stop |=> acquiring)
        else $error("slave missed link trigger");
    chk_master_src: assert property ( // RL10
        armed && !is_slave && src_hit && !ai_stop |=> acquiring)
        else $error("master missed a trigger source");
    chk_run_until_stop: assert property (acquiring && !ai_stop |=> acquiring) // RL13
        else $error("acquisition ended without own stop");
    chk_stop_ends_run: assert property ( // RL13
        (armed || acquiring) && ai_stop |=> !armed && !acquiring)
        else $error("own stop did not end acquisition");
    chk_slave_clock: assert property (is_slave && lclk_rise |=> ##0 pif.base_tick) // RL3
        else $error("slave base tick not from link clock");
    chk_none_local_clock: assert property ( // RL6
        mode_now == `ACQ_MODE_CODE_NONE && local_rise |=> pif.base_tick && ao_tick)
        else $error("none mode base tick not from local clock");

    cov_master_run: cover property (link_oe && armed ##1 acquiring ##[1:200] sample_tick);
    cov_slave_run:  cover property (is_slave && armed ##1 acquiring ##[1:200] sample_tick);
    cov_none_stop:  cover property (mode_now == `ACQ_MODE_CODE_NONE && acquiring ##1 !acquiring);
    cov_slave_on:   cover property (
        is_slave && acquiring && $fell(s_reg.ltrig_lvl) ##[1:200] sample_tick);

endmodule // multi_module_acq_sync
`default_nettype wire

// ===== logic/acq_sync_defines.svh
// Named constants for the multi-module acquisition synchronisation block.
`ifndef ACQ_SYNC_DEFINES_SVH
`define ACQ_SYNC_DEFINES_SVH

`define ACQ_CLK_PERIOD_NS   20
`define ACQ_BASE_PERIOD_NS  1000
`define ACQ_BASE_HALF_CYC   ((`ACQ_BASE_PERIOD_NS / `ACQ_CLK_PERIOD_NS) / 2)
`define ACQ_DIV_W           8
`define ACQ_SYNC_DEPTH      3
`define ACQ_MODE_CODE_NONE   2'h0
`define ACQ_MODE_CODE_MASTER 2'h1
`define ACQ_MODE_CODE_SLAVE  2'h2
`define ACQ_SRC_CODE_SW     2'h0
`define ACQ_SRC_CODE_EXT    2'h1
`define ACQ_SRC_CODE_THRESH 2'h2

`endif

// ===== logic/acq_sync_pkg.sv
// Types shared by the acquisition synchronisation modules.
`default_nettype none
package acq_sync_pkg;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_MASTER,
        MODE_SLAVE
    } sync_mode_e;

    typedef enum logic [1:0] {
        SRC_SW,
        SRC_EXT,
        SRC_THRESH
    } trig_src_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN
    } acq_state_e;

    typedef struct packed {
        sync_mode_e mode;
        acq_state_e state;
        logic       armed;
        logic       acquiring;
        logic [2:0] ext_sync;
        logic       ext_lvl;
        logic [2:0] ltrig_sync;
        logic       ltrig_lvl;
        logic [2:0] lclk_sync;
        logic       lclk_lvl;
        logic       thresh_prev;
        logic [7:0] div_cnt;
        logic       lclk;
        logic       base_tick;
        logic       ao_tick;
        logic       link_clk_out;
        logic       link_trig_out;
        logic       link_oe;
    } top_state_s;

endpackage
`default_nettype wire

// ===== logic/pacer_if.sv
// Carrier between the synchronisation control and the sample pacer.
`timescale 1ns/100ps
`default_nettype none
interface pacer_if #(parameter int RATE_W = 16);
    logic              base_tick;
    logic              run;
    logic [RATE_W-1:0] rate_div;
    logic              sample_tick;

    modport ctrl  (output base_tick, output run, output rate_div, input sample_tick);
    modport pacer (input base_tick, input run, input rate_div, output sample_tick);
endinterface
`default_nettype wire

// ===== logic/sample_pacer.sv
// Divides the selected base clock down to this module's own sample rate.
`timescale 1ns/100ps
`default_nettype none
module sample_pacer #(
    parameter int RATE_W = 16
) (
    input  wire logic clk_sys,    // System clock.
    input  wire logic resetn,     // Asynchronous reset, active low.
    pacer_if.pacer    pif         // Base tick, run and divider in; sample tick out.
);
    typedef struct packed {
        logic [RATE_W-1:0] cnt;
        logic              tick;
    } pacer_state_s;

    pacer_state_s s_reg;
    pacer_state_s s_next;

    generate
        if (RATE_W < 1 || RATE_W > 16) begin : g_bad_width
            $error("sample_pacer: RATE_W must lie between 1 and 16");
        end
    endgenerate

    // A fresh start always counts from zero, so the first sample falls on
    // the first base tick after the trigger on every module alike.
    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        if (!pif.run) begin
            s_next.cnt = '0;
        end else if (pif.base_tick) begin
            if (s_reg.cnt == '0) begin
                s_next.tick = 1'b1; // RL12
                s_next.cnt  = (pif.rate_div == '0) ? '0 : RATE_W'(pif.rate_div - 1'b1);
            end else begin
                s_next.cnt = RATE_W'(s_reg.cnt - 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pif.sample_tick = s_reg.tick;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_pacer_idle_quiet: assert property (!pif.run |=> !pif.sample_tick) // RL14
        else $error("sample tick while pacer stopped");
    chk_pacer_tick_cause: assert property (pif.sample_tick |-> $past(pif.base_tick)) // RL12
        else $error("sample tick without base tick");

endmodule // sample_pacer
`default_nettype wire

// ===== testbench/peer_master_model.sv
// Behavioural model of a peer module that acts as link master.
`timescale 1ns/100ps
`default_nettype none
module peer_master_model (
    input  wire logic go,        // Peer acquisition running.
    output var logic  link_clk,  // Link clock from the peer.
    output var logic  link_trig  // Link trigger, high while the peer runs.
);
    // The odd start offset keeps the peer clock unrelated in phase to clk_sys.
    initial begin
        link_clk = 1'b0;
        #137.3;
        forever #500 link_clk = ~link_clk;
    end

    initial link_trig = 1'b0;
    always @(go) link_trig <= #3 go;
endmodule // peer_master_model
`default_nettype wire

// ===== testbench/test_multi_module_acq_sync.sv
// Self-checking bench for the acquisition synchronisation block.
`timescale 1ns/100ps
`default_nettype none
module test_multi_module_acq_sync;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic [1:0]  mode_code = 2'h0, trig_src = 2'h0, mode_now;
    logic        mode_wr = 1'b0, app_exit = 1'b0, sw_trig = 1'b0;
    logic        ext_trig = 1'b0, thresh_hit = 1'b0, peer_go = 1'b0;
    logic        ai_start = 1'b0, ai_stop = 1'b0, link_clk, link_trig;
    logic [15:0] rate_div = 16'h0001;
    logic        link_clk_out, link_trig_out, link_oe, armed, acquiring;
    logic        sample_tick, ao_tick;
    int          failures = 0, comparisons = 0, exp_mode = 0, ns, na, nc;

    multi_module_acq_sync multi_module_acq_sync_i (
        .clk_sys(clk_sys), .resetn(resetn), .mode_code(mode_code),
        .mode_wr(mode_wr), .app_exit(app_exit), .trig_src(trig_src),
        .sw_trig(sw_trig), .ext_trig(ext_trig), .thresh_hit(thresh_hit),
        .ai_start(ai_start), .ai_stop(ai_stop), .rate_div(rate_div),
        .link_clk_in(link_clk), .link_trig_in(link_trig),
        .link_clk_out(link_clk_out), .link_trig_out(link_trig_out),
        .link_oe(link_oe), .mode_now(mode_now), .armed(armed),
        .acquiring(acquiring), .sample_tick(sample_tick), .ao_tick(ao_tick)
    );

    // One peer joined point to point stays within the two-module chain.
    peer_master_model peer_master_model_i (
        .go(peer_go), .link_clk(link_clk), .link_trig(link_trig)
    );

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [1:0] e, logic [1:0] g);
        comparisons++;
        if (g !== e) begin
            $display("Error %s expected %0d seen %0d", what, e, g);
            failures++;
        end
    endtask

    task automatic chk_in(string what, int lo, int hi, int g);
        comparisons++;
        if (g < lo || g > hi) begin
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, g);
            failures++;
        end
    endtask

    // Pulses are raised on a falling edge, so the next rising edge takes them.
    task automatic pulse(int w);
        @(negedge clk_sys);
        case (w)
            0: mode_wr = 1'b1;
            1: app_exit = 1'b1;
            2: sw_trig = 1'b1;
            3: ai_start = 1'b1;
            default: ai_stop = 1'b1;
        endcase
        @(negedge clk_sys);
        {mode_wr, app_exit, sw_trig, ai_start, ai_stop} = 5'h00;
        @(negedge clk_sys);
    endtask

    task automatic set_mode(logic [1:0] m);
        mode_code = m;
        pulse(0);
        if (m != 2'h3) exp_mode = m;
        chk("mode_now", 2'(exp_mode), mode_now);
    endtask

    task automatic wait_acq(logic e, int n);
        for (int i = 0; i < n && acquiring !== e; i++) @(negedge clk_sys);
        chk("acquiring", {1'b0, e}, {1'b0, acquiring});
        if (acquiring !== e) close_out();
    endtask

    task automatic count(int cyc);
        logic prev;
        prev = link_clk_out;
        ns = 0;
        na = 0;
        nc = 0;
        repeat (cyc) begin
            @(negedge clk_sys);
            ns += (sample_tick === 1'b1);
            na += (ao_tick === 1'b1);
            nc += (link_clk_out !== prev);
            prev = link_clk_out;
        end
    endtask

    initial begin
        void'($urandom(32'h7e245e67));
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        @(negedge clk_sys);
        chk("mode_now", 2'h0, mode_now);
        chk("link_oe", 2'h0, {1'b0, link_oe});
        // Local pacing at random rates; 50 system cycles make one base tick.
        for (int k = 0; k < 3; k++) begin
            rate_div = 16'($urandom_range(4, 1));
            pulse(3);
            chk("armed", 2'h1, {1'b0, armed});
            pulse(2);
            wait_acq(1'b1, 4);
            count(200 * rate_div);
            chk_in("sample_tick", 3, 5, ns);
            chk_in("ao_tick", 4 * rate_div - 1, 4 * rate_div + 1, na);
            pulse(4);
            wait_acq(1'b0, 4);
        end
        for (int m = 0; m < 4; m++) set_mode(2'(m));
        set_mode(2'h1);
        pulse(1);
        exp_mode = 0;
        chk("mode_now", 2'(exp_mode), mode_now);
        set_mode(2'h1);
        chk("link_oe", 2'h1, {1'b0, link_oe});
        for (int s = 0; s < 3; s++) begin
            trig_src = 2'(s);
            pulse(3);
            if (s == 0) pulse(2);
            if (s == 1) ext_trig = 1'b1;
            if (s == 2) thresh_hit = 1'b1;
            wait_acq(1'b1, 8);
            chk("link_trig_out", 2'h1, {1'b0, link_trig_out});
            count(1000);
            chk_in("link_clk_out", 39, 41, nc);
            pulse(4);
            wait_acq(1'b0, 4);
            chk("link_trig_out", 2'h0, {1'b0, link_trig_out});
            ext_trig = 1'b0;
            thresh_hit = 1'b0;
            repeat (6) @(negedge clk_sys);
        end
        // Source code 3 selects no trigger, so a software pulse must leave it armed.
        trig_src = 2'h3;
        pulse(3);
        pulse(2);
        chk("armed", 2'h1, {1'b0, armed});
        chk("acquiring", 2'h0, {1'b0, acquiring});
        pulse(4);
        wait_acq(1'b0, 4);
        chk("armed", 2'h0, {1'b0, armed});
        set_mode(2'h2);
        chk("link_oe", 2'h0, {1'b0, link_oe});
        rate_div = 16'h0002;
        trig_src = 2'h1;
        pulse(3);
        pulse(2);
        ext_trig = 1'b1;
        thresh_hit = 1'b1;
        count(200);
        chk("armed", 2'h1, {1'b0, armed});
        chk_in("sample_tick", 0, 0, ns);
        peer_go = 1'b1;
        wait_acq(1'b1, 8);
        count(1000);
        chk_in("sample_tick", 9, 11, ns);
        chk_in("ao_tick", 19, 21, na);
        peer_go = 1'b0;
        count(200);
        chk("acquiring", 2'h1, {1'b0, acquiring});
        chk_in("sample_tick", 1, 3, ns);
        pulse(4);
        wait_acq(1'b0, 4);
        close_out();
    end
endmodule // test_multi_module_acq_sync
`default_nettype wire
